// ### core/eci_indicator.sv
// Purpose: error code indicator for a fieldbus gateway
// Assumes: event inputs synchronous to sys_clk, one-cycle pulses
// Notes: serious code held until reset (power cycle)
//
// Summary of operation
// - on any error, status indicator red and code shown on four outputs
// - system errors flash the code pattern at one hertz
// - code shown in binary on outputs weighted 8, 4, 2, 1
// - codes 1 to 5 latch until power is cycled
// - system warning codes shown one minute then cleared automatically
// - serious codes: hardware, nonvolatile memory, memory, fieldbus, script
// - warnings 7,8,9,10,11,13,14; codes 0,6,12,15 reserved
// - user errors flash at half a hertz
// - user warning codes (not 1 to 5) shown for the programmed warning hold time
// - in configuration mode outputs other than error_active carry no error meaning
// - script logic may drive the indicators directly
`timescale 1ns/1ps
module eci_indicator import eci_pkg::*; #(
	parameter int unsigned TICK_DIV = TICK_CYC,
	parameter int unsigned SYS_HALF = SYS_HALF_TICKS,
	parameter int unsigned USR_HALF = USR_HALF_TICKS,
	parameter int unsigned HOLD_TICKS = WARN_HOLD_TICKS
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ev_hw_fault,
	input wire logic ev_nonvolatile_memory,
	input wire logic ev_int_memory,
	input wire logic ev_fieldbus_hw,
	input wire logic ev_script,
	input wire logic ev_tx_overflow,
	input wire logic ev_rx_overflow,
	input wire logic ev_rs_timeout,
	input wire logic ev_fieldbus_general,
	input wire logic ev_parity_frame,
	input wire logic ev_fieldbus_config,
	input wire logic ev_fieldbus_buf_overflow,
	input wire logic user_err_valid,
	input wire logic [3:0] user_err_code,
	input wire logic [TIME_W-1:0] user_hold_ticks,
	input wire logic config_mode,
	input wire logic [3:0] cfg_internal_pattern,
	input wire logic script_override,
	input wire logic [3:0] script_pattern,
	input wire logic script_state_red,
	input wire logic script_state_green,
	output logic state_red,
	output logic state_green,
	output logic error_weight_eight_output,
	output logic error_weight_four_output,
	output logic error_weight_two_output,
	output logic error_weight_one_output,
	output logic error_active
);
	// elaboration checks on the timing parameters
	if (SYS_HALF < 1 || USR_HALF < 1 || HOLD_TICKS < 1) begin : g_bad_time
		$error("timing counts must be at least one");
	end
	if (HOLD_TICKS >= (1 << TIME_W)) begin : g_bad_hold
		$error("hold count too wide");
	end
	if (SYS_HALF > (1 << TIME_W) ||
		USR_HALF > (1 << TIME_W)) begin : g_bad_half
		$error("flash half period too wide");
	end

	logic tick;
	eci_state_t state_r;
	logic [3:0] code_r;
	logic user_r;
	logic [TIME_W-1:0] hold_r;
	logic [TIME_W-1:0] flash_r;
	logic phase_r;
	logic [3:0] sys_code;
	logic sys_ev;
	logic [NUM_SRC-1:0] ev_vec;
	logic [3:0] src_code [NUM_SRC];
	logic serious_ev;
	logic [3:0] serious_code;

	eci_divider #(
		.DIV(TICK_DIV)
	) u_div (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.tick(tick)
	);

	assign src_code[0] = ERR_HW_FAULT;
	assign src_code[1] = ERR_NVMEM;
	assign src_code[2] = ERR_INT_MEM;
	assign src_code[3] = ERR_FIELDBUS_HW;
	assign src_code[4] = ERR_SCRIPT;
	assign src_code[5] = ERR_TX_OVF;
	assign src_code[6] = ERR_RX_OVF;
	assign src_code[7] = ERR_RS_TIMEOUT;
	assign src_code[8] = ERR_FIELDBUS_GEN;
	assign src_code[9] = ERR_PARITY;
	assign src_code[10] = ERR_FB_CONFIG;
	assign src_code[11] = ERR_FB_BUF_OVF;

	assign ev_vec = {ev_fieldbus_buf_overflow, ev_fieldbus_config,
		ev_parity_frame, ev_fieldbus_general, ev_rs_timeout,
		ev_rx_overflow, ev_tx_overflow, ev_script, ev_fieldbus_hw,
		ev_int_memory, ev_nonvolatile_memory, ev_hw_fault};

	// lowest index wins: serious sources have priority
	always_comb begin
		sys_ev = 1'b0;
		sys_code = CODE_NONE;
		for (int i = int'(NUM_SRC) - 1; i >= 0; i--) begin
			if (ev_vec[i]) begin
				sys_ev = 1'b1;
				sys_code = src_code[i];
			end
		end
	end

	// serious range check, also for user codes
	always_comb begin
		serious_ev = 1'b0;
		serious_code = CODE_NONE;
		if (sys_ev && sys_code >= SERIOUS_MIN && sys_code <= SERIOUS_MAX) begin
			serious_ev = 1'b1;
			serious_code = sys_code;
		end else if (user_err_valid && user_err_code >= SERIOUS_MIN &&
			user_err_code <= SERIOUS_MAX) begin
			serious_ev = 1'b1;
			serious_code = user_err_code;
		end
	end

	// state and latched code
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ECI_IDLE;
			code_r <= CODE_NONE;
			user_r <= 1'b0;
		end else begin
			unique case (state_r)
				ECI_IDLE, ECI_WARN: begin
					if (serious_ev) begin
						state_r <= ECI_SERIOUS;
						code_r <= serious_code;
						// user serious code beside a system warning
						user_r <= !sys_ev || (sys_code != serious_code);
					end else if (sys_ev) begin
						state_r <= ECI_WARN;
						code_r <= sys_code;
						user_r <= 1'b0;
					end else if (user_err_valid) begin
						state_r <= ECI_WARN;
						code_r <= user_err_code;
						user_r <= 1'b1;
					end else if (state_r == ECI_WARN && tick &&
						hold_r == '0) begin
						state_r <= ECI_IDLE;
						code_r <= CODE_NONE;
						user_r <= 1'b0;
					end
				end
				ECI_SERIOUS: begin
					state_r <= ECI_SERIOUS;
				end
				default: begin
					state_r <= ECI_IDLE;
					code_r <= CODE_NONE;
					user_r <= 1'b0;
				end
			endcase
		end
	end

	// warning hold countdown in ticks
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_r <= '0;
		end else if (state_r != ECI_SERIOUS && !serious_ev &&
			sys_ev) begin
			hold_r <= TIME_W'(HOLD_TICKS - 1);
		end else if (state_r != ECI_SERIOUS && !serious_ev &&
			user_err_valid) begin
			hold_r <= (user_hold_ticks == '0) ? '0 : user_hold_ticks - 1'b1;
		end else if (tick && hold_r != '0) begin
			hold_r <= hold_r - 1'b1;
		end
	end

	// flash phase generator
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flash_r <= '0;
			phase_r <= 1'b0;
		end else if (state_r == ECI_IDLE) begin
			flash_r <= '0;
			phase_r <= 1'b1;
		end else if (tick) begin
			if (flash_r >= TIME_W'((user_r ? USR_HALF : SYS_HALF) - 1)) begin
				flash_r <= '0;
				phase_r <= !phase_r;
			end else begin
				flash_r <= flash_r + 1'b1;
			end
		end
	end

	// output selection
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_red <= 1'b0;
			state_green <= 1'b0;
			{error_weight_eight_output, error_weight_four_output,
				error_weight_two_output, error_weight_one_output} <= 4'h0;
			error_active <= 1'b0;
		end else begin
			error_active <= (state_r != ECI_IDLE);
			if (config_mode) begin
				state_red <= 1'b0;
				state_green <= 1'b0;
				{error_weight_eight_output, error_weight_four_output,
					error_weight_two_output,
					error_weight_one_output} <= cfg_internal_pattern;
			end else if (state_r != ECI_IDLE) begin
				state_red <= 1'b1;
				state_green <= 1'b0;
				{error_weight_eight_output, error_weight_four_output,
					error_weight_two_output,
					error_weight_one_output} <= phase_r ? code_r : 4'h0;
			end else if (script_override) begin
				state_red <= script_state_red;
				state_green <= script_state_green;
				{error_weight_eight_output, error_weight_four_output,
					error_weight_two_output,
					error_weight_one_output} <= script_pattern;
			end else begin
				state_red <= 1'b0;
				state_green <= 1'b0;
				{error_weight_eight_output, error_weight_four_output,
					error_weight_two_output,
					error_weight_one_output} <= 4'h0;
			end
		end
	end
endmodule : eci_indicator

// ### core/eci_pkg.sv
// Purpose: constants shared by the error code indicator
// Assumes: 40 MHz system clock
// Notes: times kept in their own units, cycle counts derived
package eci_pkg;
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned CODE_W = 4;
	// flash periods in milliseconds
	localparam int unsigned SYS_FLASH_MS = 1000;
	localparam int unsigned USR_FLASH_MS = 2000;
	// warning hold time in seconds
	localparam int unsigned WARN_HOLD_S = 60;
	// tick of 1 ms drives all slow timing
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYC = CLK_HZ / 1000000 * TICK_US;
	localparam int unsigned SYS_HALF_TICKS = SYS_FLASH_MS / 2;
	localparam int unsigned USR_HALF_TICKS = USR_FLASH_MS / 2;
	localparam int unsigned WARN_HOLD_TICKS = WARN_HOLD_S * 1000;
	localparam int unsigned TIME_W = 20;
	localparam logic [3:0] SERIOUS_MIN = 4'h1;
	localparam logic [3:0] SERIOUS_MAX = 4'h5;
	localparam logic [3:0] CODE_NONE = 4'h0;
	// serious codes
	localparam logic [3:0] ERR_HW_FAULT = 4'h1;
	localparam logic [3:0] ERR_NVMEM = 4'h2;
	localparam logic [3:0] ERR_INT_MEM = 4'h3;
	localparam logic [3:0] ERR_FIELDBUS_HW = 4'h4;
	localparam logic [3:0] ERR_SCRIPT = 4'h5;
	// warning codes
	localparam logic [3:0] ERR_TX_OVF = 4'h7;
	localparam logic [3:0] ERR_RX_OVF = 4'h8;
	localparam logic [3:0] ERR_RS_TIMEOUT = 4'h9;
	localparam logic [3:0] ERR_FIELDBUS_GEN = 4'ha;
	localparam logic [3:0] ERR_PARITY = 4'hb;
	localparam logic [3:0] ERR_FB_CONFIG = 4'hd;
	localparam logic [3:0] ERR_FB_BUF_OVF = 4'he;
	localparam int unsigned NUM_SRC = 12;
	typedef enum logic [2:0] {
		ECI_IDLE = 3'b001,
		ECI_WARN = 3'b010,
		ECI_SERIOUS = 3'b100
	} eci_state_t;
endpackage : eci_pkg

// ### core/eci_divider.sv
// Purpose: one-cycle enable pulse every TICK_CYC clocks
// Assumes: single clock domain
// Notes: all slow timing of the indicator counts these pulses
`timescale 1ns/1ps
module eci_divider import eci_pkg::*; #(
	parameter int unsigned DIV = TICK_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	output logic tick
);
	localparam int unsigned CW = $clog2(DIV + 1);
	logic [CW-1:0] cnt_r;

	if (DIV < 1) begin : g_bad_div
		$error("divider must be at least one");
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else if (cnt_r == CW'(DIV - 1)) begin
			cnt_r <= '0;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule : eci_divider

// ### tb/eci_assertions.sv
// Purpose: port checker for the error code indicator
// Assumes: single clock, reset low active
// Notes: attached by bind at the foot
`timescale 1ns/1ps
module eci_checker (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ev_hw_fault,
	input wire logic ev_script,
	input wire logic ev_tx_overflow,
	input wire logic config_mode,
	input wire logic script_override,
	input wire logic script_state_red,
	input wire logic state_red,
	input wire logic error_active
);
	logic [1:0] ser_cnt_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// cycles since a serious event, saturating
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			ser_cnt_r <= 2'h0;
		else if (ser_cnt_r != 2'h0 || ev_hw_fault || ev_script)
			ser_cnt_r <= (ser_cnt_r == 2'h3) ? 2'h3 : ser_cnt_r + 2'h1;
	end
	property p_reset_quiet;
		$rose(rst_n) |-> !error_active && !state_red;
	endproperty
	property p_serious_raise;
		ev_hw_fault || ev_script |-> ##[1:3] error_active;
	endproperty
	property p_warn_raise;
		ev_tx_overflow |-> ##[1:3] error_active;
	endproperty
	property p_serious_latch;
		ser_cnt_r == 2'h3 |-> error_active;
	endproperty
	property p_serious_red;
		ser_cnt_r == 2'h3 && !config_mode && !$past(config_mode)
			&& !$past(config_mode, 2) |-> state_red;
	endproperty
	property p_config_mask;
		config_mode [*2] |-> !state_red;
	endproperty
	property p_idle_dark;
		(!error_active && !script_override && !config_mode) [*3]
			|-> !state_red;
	endproperty
	property p_script_red;
		(script_override && script_state_red && !config_mode
			&& !error_active) [*3] |-> state_red;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("outputs active after reset");
	a_serious_raise: assert property (p_serious_raise)
		else $error("serious event not shown");
	a_warn_raise: assert property (p_warn_raise)
		else $error("warning event not shown");
	a_serious_latch: assert property (p_serious_latch)
		else $error("serious error not held");
	a_serious_red: assert property (p_serious_red)
		else $error("status not red on serious error");
	a_config_mask: assert property (p_config_mask)
		else $error("red shown in configuration mode");
	a_idle_dark: assert property (p_idle_dark)
		else $error("red without error");
	a_script_red: assert property (p_script_red)
		else $error("script red not followed");
	c_serious: cover property (ser_cnt_r == 2'h3);
	c_config: cover property (config_mode [*2]);
	c_clear: cover property ($fell(error_active));
endmodule : eci_checker

bind eci_indicator eci_checker u_chk (.sys_clk, .rst_n, .ev_hw_fault,
	.ev_script, .ev_tx_overflow, .config_mode, .script_override,
	.script_state_red, .state_red, .error_active);

// ### tb/testbench.sv
// Purpose: self-checking bench for the error code indicator
// Assumes: shortened timing parameters, tick of 4 cycles
// Notes: outputs sampled on the falling edge
`timescale 1ns/1ps
module testbench;
	`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
		n_fail++; $display("[ERR] %0t got %h exp %h", $time, a, b); \
		end end
	logic sys_clk = 1'b0, rst_n = 1'b0, uv = 1'b0, cm = 1'b0;
	logic so = 1'b0, sr = 1'b0, sg = 1'b0, red, grn, act, w8, w4, w2, w1;
	logic [11:0] ev = 12'h000;
	logic [3:0] uc = 4'h6, cp = 4'h0, sp = 4'h0;
	logic [19:0] uh = 20'h00028;
	logic [3:0] codes [12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7,
		4'h8, 4'h9, 4'ha, 4'hb, 4'hd, 4'he};
	int n_fail = 0, tests_run = 0, cyc = 0;
	eci_indicator #(.TICK_DIV(4), .SYS_HALF(2), .USR_HALF(4),
		.HOLD_TICKS(20)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
		.ev_hw_fault(ev[0]), .ev_nonvolatile_memory(ev[1]),
		.ev_int_memory(ev[2]), .ev_fieldbus_hw(ev[3]), .ev_script(ev[4]),
		.ev_tx_overflow(ev[5]), .ev_rx_overflow(ev[6]),
		.ev_rs_timeout(ev[7]), .ev_fieldbus_general(ev[8]),
		.ev_parity_frame(ev[9]), .ev_fieldbus_config(ev[10]),
		.ev_fieldbus_buf_overflow(ev[11]), .user_err_valid(uv),
		.user_err_code(uc), .user_hold_ticks(uh), .config_mode(cm),
		.cfg_internal_pattern(cp), .script_override(so),
		.script_pattern(sp), .script_state_red(sr),
		.script_state_green(sg), .state_red(red), .state_green(grn),
		.error_weight_eight_output(w8), .error_weight_four_output(w4),
		.error_weight_two_output(w2), .error_weight_one_output(w1),
		.error_active(act));
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) cyc <= cyc + 1;
	function automatic logic [3:0] pat();
		return {w8, w4, w2, w1};
	endfunction : pat
	task automatic clk(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : clk
	task automatic do_reset;
		clk(1);
		rst_n <= 1'b0;
		clk(3);
		rst_n <= 1'b1;
		@(negedge sys_clk);
		`CHK({act, red, grn, pat()}, 7'h00)
	endtask : do_reset
	// falling edges until the shown pattern changes
	task automatic wait_chg(output int n);
		logic [3:0] p;
		p = pat();
		n = 0;
		while (pat() === p && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
	endtask : wait_chg
	task automatic t_show(input int i, input logic [3:0] code,
		input int half, input int hold);
		int n, t0;
		do_reset();
		clk(1);
		if (i < 12) ev[i] <= 1'b1;
		else uv <= 1'b1;
		clk(1);
		ev <= 12'h000;
		uv <= 1'b0;
		t0 = cyc;
		clk(2);
		@(negedge sys_clk);
		`CHK({act, red, pat()}, {2'b11, code})
		wait_chg(n);
		wait_chg(n);
		`CHK(n, half)
		while (act !== 1'b0 && cyc - t0 < 400) @(negedge sys_clk);
		n = cyc - t0;
		`CHK(n >= hold - 4 && n <= hold + 10, 1'b1)
	endtask : t_show
	task automatic t_serious(input int i);
		int n;
		do_reset();
		clk(1);
		ev[5] <= 1'b1;
		clk(1);
		ev <= 12'h000;
		clk(2);
		ev[i] <= 1'b1;
		clk(1);
		ev <= 12'h000;
		clk(3);
		ev[6] <= 1'b1;
		@(negedge sys_clk);
		`CHK({act, red, pat()}, {2'b11, codes[i]})
		clk(1);
		ev <= 12'h000;
		repeat (2) begin
			clk(100);
			@(negedge sys_clk);
			if (pat() === 4'h0) wait_chg(n);
			`CHK({act, red, pat()}, {2'b11, codes[i]})
		end
		clk(1);
		cm <= 1'b1;
		cp <= 4'ha;
		clk(3);
		@(negedge sys_clk);
		`CHK({red, grn, pat()}, {2'b00, 4'ha})
		clk(1);
		cm <= 1'b0;
		clk(4);
	endtask : t_serious
	task automatic t_user_serious;
		int n;
		do_reset();
		clk(1);
		uc <= 4'h3;
		uv <= 1'b1;
		clk(1);
		uv <= 1'b0;
		uc <= 4'h6;
		clk(200);
		@(negedge sys_clk);
		if (pat() === 4'h0) wait_chg(n);
		`CHK({act, red, pat()}, {2'b11, 4'h3})
		wait_chg(n);
		wait_chg(n);
		`CHK(n, 16)
	endtask : t_user_serious
	task automatic t_script;
		do_reset();
		clk(1);
		so <= 1'b1;
		sp <= 4'h9;
		sr <= 1'b1;
		sg <= 1'b1;
		clk(3);
		@(negedge sys_clk);
		`CHK({red, grn, pat()}, {2'b11, 4'h9})
	endtask : t_script
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		#(25 * 10000);
		n_fail++;
		end_of_test();
	end
	initial begin
		for (int i = 5; i < 12; i++) t_show(i, codes[i], 8, 80);
		t_show(12, 4'h6, 16, 160);
		for (int i = 0; i < 5; i++) t_serious(i);
		t_user_serious();
		t_script();
		end_of_test();
	end
endmodule : testbench
